// File: hdl/gfs_pkg.sv
// Package of constants, states and carriers for the gas monitor fault supervisor
`default_nettype none
package gfs_pkg;
    // Clock rate
    localparam int unsigned CLK_KHZ      = 250000;
    // Times in their own units
    localparam int unsigned WARM_MS      = 2000;
    localparam int unsigned WDOG_MS      = 32;
    localparam int unsigned HOLD_US      = 100;
    // Derived cycle counts
    localparam int unsigned WARM_CYC     = WARM_MS * CLK_KHZ;
    localparam int unsigned WDOG_CYC     = WDOG_MS * CLK_KHZ;
    localparam int unsigned HOLD_CYC     = (HOLD_US * CLK_KHZ) / 1000;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_ALARM    = 8'h08;
    localparam logic [7:0] ADDR_BASE     = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_GAS      = 8'h18;
    // Control field positions
    localparam int CTRL_MODE_BIT         = 0;
    localparam int CTRL_KICK_BIT         = 1;
    localparam int CTRL_CAPT_BIT         = 2;
    // Interrupt bit positions
    localparam int IRQ_SENSOR            = 0;
    localparam int IRQ_TEMP              = 1;
    localparam int IRQ_CSUM              = 2;
    localparam int IRQ_WDOG              = 3;
    localparam int IRQ_REFUSE            = 4;
    localparam int IRQ_ALARM             = 5;
    localparam int IRQ_W                 = 6;
    // Reset values and limits
    localparam logic [7:0] ALARM_RST     = 8'h80;
    localparam logic [7:0] CAPT_LIMIT    = 8'h20;
    localparam logic [7:0] FULL_SCALE    = 8'hFF;
    localparam logic signed [7:0] TEMP_HI = 8'sh50;
    localparam logic signed [7:0] TEMP_LO = -8'sh28;
    // Device states
    typedef enum logic [2:0] {
        ST_WARMUP = 3'b000,
        ST_NORMAL = 3'b001,
        ST_ALARM  = 3'b010,
        ST_ERROR  = 3'b011,
        ST_RESET  = 3'b100
    } gfs_state_t;
    // Power-up checksum results from the memory checker
    typedef struct packed {
        logic done;
        logic fw_ok;
        logic cal_ok;
    } gfs_csum_t;
endpackage : gfs_pkg
`default_nettype wire

// File: hdl/gfs_top.sv
// Fault supervisor for a gas monitor with APB registers and interrupt
//
// Contract
// - Config bit picks error or alarm reporting
// - Missing or broken sensor raises sensor fault
// - Sensor fault clears when sensor returns
// - Temperature outside limits raises self-clearing fault
// - Watchdog expiry resets system into warm-up
// - Supply low holds device in reset
// - Supply low forces output and relay inactive
// - Firmware checksum failure latches error state; with the config bit set to alarm reporting the code enters ST_ALARM instead
// - Calibration/config checksum failure also latches error; with the config bit set to alarm reporting the code enters ST_ALARM instead
// - Refuse baseline capture at high gas
// - Warm-up two seconds, zero readings
// - Error state outputs full-scale readings
// - Watchdog and supply faults reset, not error
// - All faults cleared returns to normal
//
// Implementation choices: the APB slave port and the placing of the registers.
`default_nettype none
module gfs_top
    import gfs_pkg::*;
#(
    parameter int unsigned WARM_CYCLES = gfs_pkg::WARM_CYC,
    parameter int unsigned WDOG_CYCLES = gfs_pkg::WDOG_CYC,
    parameter int unsigned HOLD_CYCLES = gfs_pkg::HOLD_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              sensor_present,
    input  wire logic signed [7:0] temp_c,
    input  wire logic              supply_low,
    input  wire logic [7:0]        gas_raw,
    input  wire gfs_pkg::gfs_csum_t csum,
    input  wire logic              program_health_watchdog_kick,
    output logic [2:0]             dev_state,
    output logic [7:0]             reading,
    output logic                   ttl_out,
    output logic                   relay_out,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    gfs_state_t        state_reg, state_next;   // Device state
    logic [31:0]       tmr_reg;                 // Warm-up and reset hold timer
    logic [31:0]       wdog_reg;                // Watchdog count
    logic              mode_reg;                // 1: faults report as alarm
    logic [7:0]        alarm_reg;               // Alarm threshold
    logic [7:0]        base_reg;                // Baseline offset
    logic              sens_flt_reg;            // Sensor fault flag
    logic              temp_flt_reg;            // Temperature fault flag
    logic              fw_fail_reg;             // Firmware checksum failed
    logic              cal_fail_reg;            // Calibration checksum failed
    logic              csum_seen_reg;           // Checksum result received
    logic              refused_reg;             // Last capture was refused
    logic [IRQ_W-1:0]  istat_reg, istat_next;   // Sticky events
    logic [IRQ_W-1:0]  imask_reg;               // Interrupt enables

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire setup_phase  = psel & ~penable;
    wire xfer_done    = psel & penable & pready;
    wire wr_done      = xfer_done & pwrite;
    wire rd_done      = xfer_done & ~pwrite;
    wire hit_ctrl     = (paddr == ADDR_CTRL);
    wire hit_status   = (paddr == ADDR_STATUS);
    wire hit_alarm    = (paddr == ADDR_ALARM);
    wire hit_base     = (paddr == ADDR_BASE);
    wire hit_istat    = (paddr == ADDR_IRQ_STAT);
    wire hit_imask    = (paddr == ADDR_IRQ_MASK);
    wire hit_gas      = (paddr == ADDR_GAS);
    wire hit_any      = hit_ctrl | hit_status | hit_alarm | hit_base
                      | hit_istat | hit_imask | hit_gas;
    wire wr_ctrl      = wr_done & hit_ctrl;
    // Kick and capture are write-one strobes, never stored
    wire sw_kick      = wr_ctrl & pwdata[CTRL_KICK_BIT];
    wire capt_req     = wr_ctrl & pwdata[CTRL_CAPT_BIT];
    wire istat_rclr   = rd_done & hit_istat;

    ////////////////////////////////////////////////////////////////////////////
    // Fault and reading conditions
    // Live level checks for sensor and temperature; their flags follow their causes, no latch needed
    wire sens_bad     = ~sensor_present;
    wire temp_bad     = (temp_c > TEMP_HI) | (temp_c < TEMP_LO);
    wire csum_bad     = fw_fail_reg | cal_fail_reg;
    wire any_fault    = sens_flt_reg | temp_flt_reg | csum_bad;
    // Net reading floors at zero below the baseline
    wire [7:0] net    = (gas_raw > base_reg) ? gas_raw - base_reg : 8'h00;
    wire gas_alarm    = (net >= alarm_reg);
    wire capt_ok      = (net < CAPT_LIMIT);
    wire kick         = program_health_watchdog_kick | sw_kick;
    wire wdog_expire  = (wdog_reg >= WDOG_CYCLES - 1);
    wire tmr_done     = (tmr_reg >= WARM_CYCLES - 1);
    wire hold_done    = (tmr_reg >= HOLD_CYCLES - 1);
    wire in_reset     = (state_reg == ST_RESET);
    wire in_error     = (state_reg == ST_ERROR);
    wire in_alarm     = (state_reg == ST_ALARM);
    wire in_warm      = (state_reg == ST_WARMUP);
    wire run_state    = ~in_reset & ~in_warm;
    wire fault_alarm  = any_fault & mode_reg;
    wire fault_error  = any_fault & ~mode_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Next device state
    // Supply low and watchdog outrank every fault: both are resets
    always_comb begin
        state_next = state_reg;
        if (supply_low) begin
            state_next = ST_RESET;
        end else if (wdog_expire && !in_reset) begin
            state_next = ST_RESET;
        end else begin
            unique case (state_reg)
                ST_RESET: begin
                    // Leaves only once supply is good and hold has run
                    if (hold_done) begin
                        state_next = ST_WARMUP;
                    end
                end
                ST_WARMUP: begin
                    // Needs time and a checksum verdict; faults skip normal
                    if (tmr_done && csum_seen_reg) begin
                        if (fault_error) begin
                            state_next = ST_ERROR;
                        end else if (fault_alarm || gas_alarm) begin
                            state_next = ST_ALARM;
                        end else begin
                            state_next = ST_NORMAL;
                        end
                    end
                end
                ST_NORMAL, ST_ALARM, ST_ERROR: begin
                    if (fault_error) begin
                        state_next = ST_ERROR;
                    end else if (fault_alarm || gas_alarm) begin
                        state_next = ST_ALARM;
                    end else begin
                        state_next = ST_NORMAL;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt events; a new event beats the read clear
    wire [IRQ_W-1:0] ev;
    assign ev[IRQ_SENSOR] = sens_bad & ~sens_flt_reg;
    assign ev[IRQ_TEMP]   = temp_bad & ~temp_flt_reg;
    assign ev[IRQ_CSUM]   = csum.done & ~(csum.fw_ok & csum.cal_ok);
    assign ev[IRQ_WDOG]   = wdog_expire & ~in_reset;
    assign ev[IRQ_REFUSE] = capt_req & ~capt_ok;
    assign ev[IRQ_ALARM]  = (state_next == ST_ALARM) & ~in_alarm;
    assign istat_next     = (istat_rclr ? '0 : istat_reg) | ev;

    ////////////////////////////////////////////////////////////////////////////
    // Read data mux
    wire [31:0] rd_status = {22'h000000, refused_reg, supply_low, cal_fail_reg,
                             fw_fail_reg, temp_flt_reg, sens_flt_reg, 1'b0,
                             state_reg};
    wire [31:0] rd_mux =
          hit_ctrl   ? {31'h0, mode_reg}
        : hit_status ? rd_status
        : hit_alarm  ? {24'h000000, alarm_reg}
        : hit_base   ? {24'h000000, base_reg}
        : hit_istat  ? {26'h0000000, istat_reg}
        : hit_imask  ? {26'h0000000, imask_reg}
        : hit_gas    ? {24'h000000, reading}
        :              32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: ready in the cycle after setup, one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            // No wait states; an access always ends in one cycle
            pready  <= setup_phase;
            prdata  <= setup_phase && !pwrite ? rd_mux : 32'h00000000;
            pslverr <= setup_phase & ~hit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg  <= 1'b0;
            alarm_reg <= ALARM_RST;
            imask_reg <= '0;
        end else begin
            if (wr_ctrl) begin
                mode_reg <= pwdata[CTRL_MODE_BIT];
            end
            if (wr_done && hit_alarm) begin
                alarm_reg <= pwdata[7:0];
            end
            if (wr_done && hit_imask) begin
                imask_reg <= pwdata[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Baseline capture; a refused request keeps the old offset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_reg    <= 8'h00;
            refused_reg <= 1'b0;
        end else if (capt_req && run_state) begin
            refused_reg <= ~capt_ok;
            if (capt_ok) begin
                base_reg <= gas_raw;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault flags
    // Sensor and temperature flags are separate so one clearing
    // cannot hide the other
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sens_flt_reg  <= 1'b0;
            temp_flt_reg  <= 1'b0;
            fw_fail_reg   <= 1'b0;
            cal_fail_reg  <= 1'b0;
            csum_seen_reg <= 1'b0;
        end else begin
            sens_flt_reg <= sens_bad;
            temp_flt_reg <= temp_bad;
            // Checksum verdict sticks until power-on reset
            if (csum.done) begin
                csum_seen_reg <= 1'b1;
                fw_fail_reg   <= fw_fail_reg | ~csum.fw_ok;
                cal_fail_reg  <= cal_fail_reg | ~csum.cal_ok;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State, timers and watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_WARMUP;
            tmr_reg   <= 32'h00000000;
            wdog_reg  <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            // Timer restarts at every change of state
            tmr_reg   <= (state_next != state_reg) ? 32'h00000000 : tmr_reg + 32'h1;
            // Kicked by the control sequence; held clear during reset
            if (kick || in_reset || state_next == ST_RESET) begin
                wdog_reg <= 32'h00000000;
            end else begin
                wdog_reg <= wdog_reg + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_reg <= '0;
            irq       <= 1'b0;
            dev_state <= ST_WARMUP;
            reading   <= 8'h00;
            ttl_out   <= 1'b0;
            relay_out <= 1'b0;
        end else begin
            // Irq follows the merged value, so it lags no event
            istat_reg <= istat_next;
            irq       <= |(istat_next & imask_reg);
            dev_state <= state_next;
            // Zero while warming, full scale on error for fail safe
            unique case (state_next)
                ST_WARMUP, ST_RESET: reading <= 8'h00;
                ST_ERROR:            reading <= FULL_SCALE;
                default:             reading <= net;
            endcase
            // Reset state drives both low so loss of power is visible
            ttl_out   <= (state_next == ST_ALARM);
            relay_out <= (state_next == ST_ALARM);
        end
    end

endmodule : gfs_top
`default_nettype wire

// File: tb/gfs_checker_assertions.sv
// Concurrent checks on the fault supervisor ports
`default_nettype none
module gfs_checker
    import gfs_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = 200
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              sensor_present,
    input wire logic signed [7:0] temp_c,
    input wire logic              supply_low,
    input wire gfs_pkg::gfs_csum_t csum,
    input wire logic              program_health_watchdog_kick,
    input wire logic [2:0]        dev_state,
    input wire logic [7:0]        reading,
    input wire logic              ttl_out,
    input wire logic              relay_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] wd_cnt;   // Cycles since last service
    logic        bad_seen; // Memory check failed since power-up
    // Service by pin or by control write
    wire kick_w = program_health_watchdog_kick | (psel & penable & pwrite
                  & (paddr == ADDR_CTRL) & pwdata[CTRL_KICK_BIT]);
    wire idle_w = (dev_state == ST_WARMUP) | (dev_state == ST_RESET);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog age; warm-up and reset restart it, so it never overstates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt <= '0;
        end else begin
            wd_cnt <= (kick_w | idle_w) ? '0 : wd_cnt + 32'h1;
        end
    end
    // Only a power-on reset forgets a failed memory check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_seen <= 1'b0;
        end else if (csum.done && !(csum.fw_ok && csum.cal_ok)) begin
            bad_seen <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Fault conditions held long enough for flag plus state update
    sequence s_low_held;
        supply_low [*3];
    endsequence
    sequence s_sensor_gone;
        (!sensor_present && !supply_low
         && dev_state inside {ST_NORMAL, ST_ALARM, ST_ERROR}) [*3];
    endsequence
    sequence s_temp_bad;
        ((temp_c > TEMP_HI || temp_c < TEMP_LO) && sensor_present && !supply_low
         && dev_state inside {ST_NORMAL, ST_ALARM, ST_ERROR}) [*3];
    endsequence
    a_supply_to_reset: assert property (supply_low |-> ##[1:2] dev_state == ST_RESET)
        else $error("supply low did not reset");
    a_supply_out_low: assert property (s_low_held |-> !ttl_out && !relay_out)
        else $error("outputs active in low supply");
    a_idle_read_zero: assert property (idle_w && $past(idle_w) |-> reading == 8'h00)
        else $error("reading not zero while idle");
    a_error_full_scale: assert property (
        (dev_state == ST_ERROR) && $past(dev_state) == ST_ERROR |-> reading == FULL_SCALE)
        else $error("error reading not full scale");
    a_sensor_fault_err: assert property (s_sensor_gone |-> dev_state != ST_NORMAL)
        else $error("sensor loss not reported");
    a_temp_fault_err: assert property (s_temp_bad |-> dev_state != ST_NORMAL)
        else $error("temperature fault not reported");
    a_wdog_bounded: assert property (wd_cnt < WDOG_CYCLES + 4)
        else $error("watchdog did not reset");
    a_csum_latched: assert property (bad_seen |-> dev_state != ST_NORMAL)
        else $error("checksum failure left");
endmodule : gfs_checker
bind gfs_top gfs_checker #(.WDOG_CYCLES(WDOG_CYCLES)) u_gfs_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .sensor_present(sensor_present), .temp_c(temp_c), .supply_low(supply_low),
    .csum(csum), .program_health_watchdog_kick(program_health_watchdog_kick),
    .dev_state(dev_state), .reading(reading), .ttl_out(ttl_out), .relay_out(relay_out)
);
`default_nettype wire

// File: tb/gfs_sense_model.sv
// Behavioural sensor, temperature, supply and memory check front end
`default_nettype none
module gfs_sense_model
    import gfs_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              want_present,
    input  wire logic signed [7:0] want_temp,
    input  wire logic              want_low,
    input  wire logic [7:0]        want_gas,
    input  wire logic              fw_good,
    input  wire logic              cal_good,
    output logic                   sensor_present,
    output logic signed [7:0]      temp_c,
    output logic                   supply_low,
    output logic [7:0]             gas_raw,
    output gfs_pkg::gfs_csum_t     csum
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] csum_dly; // Cycles since power-up, held at 15
    wire        verdict = (csum_dly == 4'h9);
    ////////////////////////////////////////////////////////////////////////////////
    // Front end settles one cycle after each change
    always_ff @(posedge pclk) begin
        sensor_present <= want_present;
        temp_c         <= want_temp;
        supply_low     <= want_low;
        gas_raw        <= want_gas;
    end
    // One verdict per power-up; the result lines are junk outside it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csum_dly <= 4'h0;
            csum     <= '0;
        end else begin
            csum_dly    <= (csum_dly == 4'hF) ? csum_dly : csum_dly + 4'h1;
            csum.done   <= verdict;
            csum.fw_ok  <= verdict ? fw_good : ~fw_good;
            csum.cal_ok <= verdict ? cal_good : ~cal_good;
        end
    end
endmodule : gfs_sense_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the fault supervisor
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gfs_pkg::*;
    localparam int W = 50;  // Short warm-up
    localparam int D = 200; // Short watchdog
    localparam int H = 5;   // Short reset hold
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, kick, er;
    logic [7:0] paddr, gas_raw, reading, want_gas;
    logic [31:0] pwdata, prdata, rd;
    logic sensor_present, supply_low, ttl_out, relay_out, irq;
    logic want_present, want_low, fw_good, cal_good;
    logic signed [7:0] temp_c, want_temp;
    logic [2:0] dev_state;
    gfs_csum_t csum;
    int err_count, n_compared;
    gfs_top #(.WARM_CYCLES(W), .WDOG_CYCLES(D), .HOLD_CYCLES(H)) u_gfs_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sensor_present(sensor_present), .temp_c(temp_c),
        .supply_low(supply_low), .gas_raw(gas_raw), .csum(csum),
        .program_health_watchdog_kick(kick), .dev_state(dev_state), .reading(reading),
        .ttl_out(ttl_out), .relay_out(relay_out), .irq(irq));
    gfs_sense_model u_gfs_sense_model (
        .pclk(pclk), .presetn(presetn), .want_present(want_present), .want_temp(want_temp),
        .want_low(want_low), .want_gas(want_gas), .fw_good(fw_good), .cal_good(cal_good),
        .sensor_present(sensor_present), .temp_c(temp_c), .supply_low(supply_low),
        .gas_raw(gas_raw), .csum(csum));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s exp %0h got %0h", nm, e, g);
            err_count++;
        end
    endtask : chk
    // One APB transfer, request held until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Bounded wait for a state, then judged
    task automatic wait_st(input logic [2:0] s, input int n);
        for (int i = 0; i < n && dev_state !== s; i++) @(posedge pclk);
        chk("dev_state", {29'h0, s}, {29'h0, dev_state});
    endtask : wait_st
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_warm();
        repeat (W / 2) @(posedge pclk);
        chk("warm_read", 32'h0, {24'h0, reading});
        chk("warm_state", ST_WARMUP, dev_state);
        wait_st(ST_NORMAL, W + 40);
    endtask : t_warm
    task automatic t_regs();
        apb(1'b0, ADDR_ALARM, 32'h0);
        chk("alarm_rst", {24'h0, ALARM_RST}, rd);
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl_mode", 32'h1, rd & 32'h1);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
    endtask : t_regs
    // Mode then temperature limits, both edges of each limit
    task automatic t_temp();
        logic signed [7:0] tv [4] = '{8'sd81, 8'sd80, -8'sd41, -8'sd40};
        logic [2:0] sv [4] = '{ST_ALARM, ST_NORMAL, ST_ERROR, ST_NORMAL};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_CTRL, {31'h0, i < 2});
            want_temp <= tv[i];
            wait_st(sv[i], 10);
            repeat (3) @(posedge pclk);
            chk("temp_state", sv[i], dev_state);
        end
    endtask : t_temp
    // Two faults overlap; irq masked for one of them
    task automatic t_fault();
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1 << IRQ_SENSOR);
        want_present <= 1'b0;
        wait_st(ST_ERROR, 10);
        @(posedge pclk);
        chk("err_read", 32'hFF, reading);
        chk("irq_on", 32'h1, irq);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("stat_sensor", 32'h1, rd[IRQ_SENSOR]);
        chk("irq_off", 32'h0, irq);
        want_temp <= 8'sd90;
        repeat (4) @(posedge pclk);
        chk("irq_masked", 32'h0, irq);
        want_present <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("still_err", ST_ERROR, dev_state);
        want_temp <= 8'sd25;
        wait_st(ST_NORMAL, 10);
    endtask : t_fault
    // Refused at high net gas, accepted just below the limit
    task automatic t_capt();
        want_gas <= 8'h35;
        repeat (4) @(posedge pclk);
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_CAPT_BIT);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("refused", 32'h1, rd[9]);
        apb(1'b0, ADDR_BASE, 32'h0);
        chk("base_kept", 32'h0, rd);
        want_gas <= 8'h1F;
        repeat (4) @(posedge pclk);
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_CAPT_BIT);
        apb(1'b0, ADDR_BASE, 32'h0);
        chk("base_new", 32'h1F, rd);
    endtask : t_capt
    task automatic t_wdog();
        kick <= 1'b0;
        repeat (D / 2) @(posedge pclk);
        chk("wd_early", ST_NORMAL, dev_state);
        wait_st(ST_WARMUP, D + 40);
        kick <= 1'b1;
        wait_st(ST_NORMAL, W + 40);
    endtask : t_wdog
    // Low supply taken while the outputs are active
    task automatic t_supply();
        want_gas <= 8'hA0;
        wait_st(ST_ALARM, 10);
        @(posedge pclk);
        chk("out_alarm", 32'h3, {ttl_out, relay_out});
        want_low <= 1'b1;
        wait_st(ST_RESET, 4);
        repeat (20) @(posedge pclk);
        chk("low_hold", ST_RESET, dev_state);
        chk("low_out", 32'h0, {ttl_out, relay_out});
        want_low <= 1'b0;
        want_gas <= 8'h05;
        wait_st(ST_WARMUP, H + 10);
        wait_st(ST_NORMAL, W + 40);
    endtask : t_supply
    task automatic t_csum();
        for (int i = 0; i < 2; i++) begin
            fw_good  <= (i != 0);
            cal_good <= (i != 1);
            do_reset();
            wait_st(ST_ERROR, W + 40);
            repeat (30) @(posedge pclk);
            chk("csum_latch", ST_ERROR, dev_state);
            chk("csum_read", 32'hFF, reading);
        end
    endtask : t_csum
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Hang guard, well beyond the planned run
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        complete_run();
    end
    initial begin
        {presetn, psel, penable, pwrite, want_low} <= '0;
        {kick, want_present, fw_good, cal_good} <= '1;
        paddr <= '0;
        pwdata <= '0;
        want_temp <= 8'sd25;
        want_gas <= 8'h05;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_warm();
        t_regs();
        t_temp();
        t_fault();
        t_capt();
        t_wdog();
        t_supply();
        t_csum();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
